// *** core/uwb_top.v ***
// upstream window base registers with two-stage claim and translation
//
// Contract
// - window 1 bit 0 shows memory or io, bits 2:1 the decode width.
// - bit 3 of both windows is a read-only prefetchable flag.
// - window 1 base bits 31:6 are writable where setup bits are one, but memory bits 11:6 never; memory bit 31 and io bits 31:8 always.
// - setup bit 31 at zero disables window 1 claims and its mask readback; its base register stays writable and readable.
// - window 1 spans 4KB to 2GB for memory and 64B to 256B for io.
// - window 1 hits are translated through the translated-base value.
// - window 1 setup is loaded by eeprom, smbus or the local cpu.
// - window 2 decode width always reads 32-bit only.
// - window 2 is memory only, base bits 31:14, 16KB to 2GB in size.
// - window 2 splits into 64 pages, each translated by a table entry.
// - page size follows the forwarding control setting.
// - a table entry with bit 0 clear disables its page.
// - window 2 writable base bits depend on the page size.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "uwb_regs.vh"
module uwb_top #(
  parameter AW = 12
) (
  input  wire          sys_clk_in,
  input  wire          srst_in,
  input  wire          ce_in,
  input  wire [AW-1:0] reg_addr_in,
  input  wire [31:0]   reg_wdata_in,
  input  wire          reg_wr_in,
  input  wire          reg_rd_in,
  output wire [31:0]   reg_rdata_out,
  input  wire [31:0]   w1_setup_in,
  input  wire [31:0]   w1_trans_in,
  input  wire [4:0]    fwd_page_code_in,
  input  wire          w2_prefetch_in,
  input  wire          req_valid_in,
  input  wire [31:0]   req_addr_in,
  input  wire          req_io_in,
  output wire          lut_rd_out,
  output wire [5:0]    lut_index_out,
  input  wire [31:0]   lut_entry_in,
  output wire          fwd_valid_out,
  output wire          fwd_claim1_out,
  output wire          fwd_claim2_out,
  output wire [31:0]   fwd_addr_out
);

  // register bank
  reg  [31:0] w1_base_q;
  reg  [31:0] w2_base_q;
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;
  reg  [31:0] last_addr_q;
  reg  [15:0] cnt1_q;
  reg  [15:0] cnt2_q;

  // stage 1: window decode
  reg         s1_v_q;
  reg         s1_hit1_q;
  reg         s1_hit2_q;
  reg  [31:0] s1_x1_q;
  reg  [31:0] s1_addr_q;
  reg         lut_rd_q;
  reg  [5:0]  lut_idx_q;

  // stage 2: page check and outputs
  reg         fwd_v_q;
  reg         claim1_q;
  reg         claim2_q;
  reg  [31:0] fwd_addr_q;

  wire [31:0] m1;
  wire        hit1;
  wire [31:0] x1;
  wire [31:0] m2;
  wire        range2;
  wire [5:0]  page2;
  wire [31:0] x2;

  wire        w1_sel = (reg_addr_in == `UWB_W1_BASE_OFF);
  wire        w2_sel = (reg_addr_in == `UWB_W2_BASE_OFF);
  wire        cnt_sel = (reg_addr_in == `UWB_CLAIM_CNT_OFF);

  uwb_win1_map u_win1 (
    .setup_in  (w1_setup_in),
    .base_in   (w1_base_q),
    .trans_in  (w1_trans_in),
    .addr_in   (req_addr_in),
    .io_in     (req_io_in),
    .mask_out  (m1),
    .hit_out   (hit1),
    .xaddr_out (x1)
  );

  uwb_win2_map u_win2 (
    .code_in       (fwd_page_code_in),
    .base_in       (w2_base_q),
    .addr_in       (req_addr_in),
    .s_addr_in     (s1_addr_q),
    .entry_in      (lut_entry_in),
    .mask_out      (m2),
    .range_hit_out (range2),
    .page_out      (page2),
    .xaddr_out     (x2)
  );

  // one saturating step, shared by both claim counters
  function [15:0] uwb_sat_inc;
    input [15:0] cnt;
    input        step;
    begin
      if (step && (cnt != 16'hFFFF)) begin
        uwb_sat_inc = cnt + 16'h0001;
      end else begin
        uwb_sat_inc = cnt;
      end
    end
  endfunction

  // a table entry opens its page only with its enable bit set
  function uwb_page_on;
    input [31:0] entry;
    begin
      uwb_page_on = entry[`UWB_ENTRY_EN_BIT];
    end
  endfunction

  // window 1 wins overlaps, so window 2 only sees what window 1 left
  wire        w2_take = req_valid_in & ~req_io_in & range2 & ~hit1;
  wire        page_on = uwb_page_on(lut_entry_in);

  // read mux; setup and page code come from the loader-owned registers
  always @* begin
    rdata_d = 32'h00000000;
    case (reg_addr_in)
      `UWB_W1_BASE_OFF: begin
        rdata_d[31:`UWB_W1_BASE_LSB] =
          w1_base_q[31:`UWB_W1_BASE_LSB] & m1[31:`UWB_W1_BASE_LSB];
        rdata_d[`UWB_PREF_BIT] = w1_setup_in[`UWB_PREF_BIT];
        // reserved width codes never show through
        rdata_d[`UWB_WIDTH_LSB] = w1_setup_in[`UWB_WIDTH_LSB];
        rdata_d[`UWB_SPACE_BIT] = w1_setup_in[`UWB_SPACE_BIT];
      end
      `UWB_W2_BASE_OFF: begin
        rdata_d[31:`UWB_W2_BASE_LSB] =
          w2_base_q[31:`UWB_W2_BASE_LSB] & m2[31:`UWB_W2_BASE_LSB];
        rdata_d[`UWB_PREF_BIT] = w2_prefetch_in;
        rdata_d[`UWB_WIDTH_MSB:`UWB_WIDTH_LSB] = `UWB_DEC_32;
      end
      `UWB_W1_MASK_OFF: begin
        rdata_d = m1 & {32{w1_setup_in[`UWB_SETUP_EN_BIT]}};
      end
      `UWB_W2_MASK_OFF: begin
        rdata_d = m2;
      end
      `UWB_LAST_ADDR_OFF: begin
        rdata_d = last_addr_q;
      end
      `UWB_CLAIM_CNT_OFF: begin
        rdata_d = {cnt2_q, cnt1_q};
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      w1_base_q <= `UWB_BASE_RST;
      w2_base_q <= `UWB_BASE_RST;
      rdata_q   <= 32'h00000000;
    end else if (ce_in) begin
      if (reg_wr_in && w1_sel) begin
        // only bits set in the size mask m1 take the write
        w1_base_q <= (w1_base_q & ~m1) | (reg_wdata_in & m1);
      end
      if (reg_wr_in && w2_sel) begin
        w2_base_q <= (w2_base_q & ~m2) | (reg_wdata_in & m2);
      end
      rdata_q <= reg_rd_in ? rdata_d : 32'h00000000;
    end
  end

  // stage 1: window 1 has priority where both windows overlap
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      s1_v_q    <= 1'b0;
      s1_hit1_q <= 1'b0;
      s1_hit2_q <= 1'b0;
      s1_x1_q   <= 32'h00000000;
      s1_addr_q <= 32'h00000000;
      lut_rd_q  <= 1'b0;
      lut_idx_q <= 6'h00;
    end else if (ce_in) begin
      s1_v_q    <= req_valid_in;
      s1_hit1_q <= req_valid_in & hit1;
      s1_hit2_q <= w2_take;
      s1_x1_q   <= x1;
      s1_addr_q <= req_addr_in;
      lut_rd_q  <= w2_take;
      lut_idx_q <= page2;
    end
  end

  // stage 2: table entry arrives with lut_index_out
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      fwd_v_q    <= 1'b0;
      claim1_q   <= 1'b0;
      claim2_q   <= 1'b0;
      fwd_addr_q <= 32'h00000000;
    end else if (ce_in) begin
      fwd_v_q  <= s1_v_q;
      claim1_q <= s1_hit1_q;
      claim2_q <= s1_hit2_q & page_on;
      if (s1_hit1_q) begin
        fwd_addr_q <= s1_x1_q;
      end else if (s1_hit2_q && page_on) begin
        fwd_addr_q <= x2;
      end else begin
        // unclaimed requests pass their address untouched
        fwd_addr_q <= s1_addr_q;
      end
    end
  end

  // claim statistics; a claim in the clearing cycle counts from one
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      last_addr_q <= 32'h00000000;
      cnt1_q      <= 16'h0000;
      cnt2_q      <= 16'h0000;
    end else if (ce_in) begin
      if (claim1_q || claim2_q) begin
        last_addr_q <= fwd_addr_q;
      end
      if (reg_wr_in && cnt_sel) begin
        cnt1_q <= {15'h0000, claim1_q};
        cnt2_q <= {15'h0000, claim2_q};
      end else begin
        // saturate instead of wrapping
        cnt1_q <= uwb_sat_inc(cnt1_q, claim1_q);
        cnt2_q <= uwb_sat_inc(cnt2_q, claim2_q);
      end
    end
  end

  assign reg_rdata_out  = rdata_q;
  assign lut_rd_out     = lut_rd_q;
  assign lut_index_out  = lut_idx_q;
  assign fwd_valid_out  = fwd_v_q;
  assign fwd_claim1_out = claim1_q;
  assign fwd_claim2_out = claim2_q;
  assign fwd_addr_out   = fwd_addr_q;

endmodule // uwb_top

// *** core/uwb_regs.vh ***
// offsets, field positions and reset values of the upstream window bases
`ifndef UWB_REGS_VH
`define UWB_REGS_VH

`define UWB_W1_BASE_OFF    12'h058
`define UWB_W2_BASE_OFF    12'h05C
`define UWB_W1_TRANS_OFF   12'h0E8
`define UWB_W1_SETUP_OFF   12'h0EC
`define UWB_FWD_CTRL_OFF   12'h06A
`define UWB_LUT_FIRST_OFF  12'h100
`define UWB_LUT_LAST_OFF   12'h1FF
`define UWB_W1_MASK_OFF    12'h200
`define UWB_W2_MASK_OFF    12'h204
`define UWB_LAST_ADDR_OFF  12'h208
`define UWB_CLAIM_CNT_OFF  12'h20C

`define UWB_BASE_RST       32'h00000000
`define UWB_SPACE_BIT      0
`define UWB_WIDTH_MSB      2
`define UWB_WIDTH_LSB      1
`define UWB_PREF_BIT       3
`define UWB_W1_BASE_LSB    6
`define UWB_W2_BASE_LSB    14
`define UWB_SETUP_EN_BIT   31
`define UWB_ENTRY_EN_BIT   0

`define UWB_W1_MEM_MIN_LSB 12
`define UWB_W1_IO_MAX_LSB  8
`define UWB_W2_PAGE_LSB0   5'd8
`define UWB_W2_WIN_LSB0    5'd14
`define UWB_W2_CODE_MAX    5'd17
`define UWB_W2_PAGE_BITS   6

`define UWB_DEC_32         2'b00
`define UWB_DEC_64         2'b01

`endif

// *** core/uwb_win1_map.v ***
// window 1 size mask, hit test and direct translation
`timescale 1ns/1ps
`include "uwb_regs.vh"
module uwb_win1_map (
  input  wire [31:0] setup_in,
  input  wire [31:0] base_in,
  input  wire [31:0] trans_in,
  input  wire [31:0] addr_in,
  input  wire        io_in,
  output wire [31:0] mask_out,
  output wire        hit_out,
  output wire [31:0] xaddr_out
);

  function [31:0] uwb_w1_mask;
    input [31:0] setup;
    reg   [31:0] m;
    begin
      m = {setup[31:`UWB_W1_BASE_LSB], 6'h00};
      if (setup[`UWB_SPACE_BIT]) begin
        // io window: 64B up to 256B
        m[31:`UWB_W1_IO_MAX_LSB] = 24'hFFFFFF;
      end else begin
        // memory window: 4KB up to 2GB
        m[`UWB_W1_MEM_MIN_LSB-1:`UWB_W1_BASE_LSB] = 6'h00;
        m[31] = 1'b1;
      end
      uwb_w1_mask = m;
    end
  endfunction

  assign mask_out  = uwb_w1_mask(setup_in);
  // disabled window never claims
  assign hit_out   = setup_in[`UWB_SETUP_EN_BIT] &
                     (io_in == setup_in[`UWB_SPACE_BIT]) &
                     ((addr_in & mask_out) == (base_in & mask_out));
  assign xaddr_out = (trans_in & mask_out) | (addr_in & ~mask_out);

endmodule // uwb_win1_map

// *** core/uwb_win2_map.v ***
// window 2 range test, page select and lookup translation
`timescale 1ns/1ps
`include "uwb_regs.vh"
module uwb_win2_map (
  input  wire [4:0]  code_in,
  input  wire [31:0] base_in,
  input  wire [31:0] addr_in,
  input  wire [31:0] s_addr_in,
  input  wire [31:0] entry_in,
  output wire [31:0] mask_out,
  output wire        range_hit_out,
  output wire [5:0]  page_out,
  output wire [31:0] xaddr_out
);

  function [31:0] uwb_hi_mask;
    input [4:0] lsb;
    begin
      uwb_hi_mask = 32'hFFFFFFFF << lsb;
    end
  endfunction

  wire [4:0]  code_c = (code_in > `UWB_W2_CODE_MAX) ? `UWB_W2_CODE_MAX
                                                    : code_in;
  wire [4:0]  page_lsb = `UWB_W2_PAGE_LSB0 + code_c;
  wire [4:0]  win_lsb  = `UWB_W2_WIN_LSB0 + code_c;
  wire [31:0] page_msk = uwb_hi_mask(page_lsb);
  wire [31:0] shifted  = addr_in >> page_lsb;

  assign mask_out      = uwb_hi_mask(win_lsb);
  assign range_hit_out = (addr_in & mask_out) == (base_in & mask_out);
  assign page_out      = shifted[`UWB_W2_PAGE_BITS-1:0];
  assign xaddr_out     = (entry_in & page_msk) | (s_addr_in & ~page_msk);

endmodule // uwb_win2_map

// *** verif/uwb_top_chk.sv ***
// port-level checker for the upstream window base block
`timescale 1ns/1ps
module uwb_top_chk (
  input wire logic        sys_clk_in,
  input wire logic        srst_in,
  input wire logic        ce_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic [31:0] w1_setup_in,
  input wire logic        req_valid_in,
  input wire logic [31:0] req_addr_in,
  input wire logic        req_io_in,
  input wire logic        lut_rd_out,
  input wire logic [31:0] lut_entry_in,
  input wire logic        fwd_valid_out,
  input wire logic        fwd_claim1_out,
  input wire logic        fwd_claim2_out,
  input wire logic [31:0] fwd_addr_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  sequence s_req;  req_valid_in && ce_in ##1 ce_in; endsequence
  sequence s_idle; !req_valid_in && ce_in ##1 ce_in; endsequence
  a_fwd_two_cycles: assert property (s_req |=> fwd_valid_out)
    else $error("forward pulse missing two cycles after request");
  a_fwd_no_spurious: assert property (s_idle |=> !fwd_valid_out)
    else $error("forward pulse without a request");
  a_rdata_idle_zero: assert property (!reg_rd_in && ce_in |=>
    reg_rdata_out == 32'h00000000) else $error("read data not cleared");
  a_lut_mem_only: assert property (lut_rd_out && $past(ce_in) |->
    $past(req_valid_in && !req_io_in))
    else $error("table look-up without a memory request");
  a_claim2_page_on: assert property (fwd_claim2_out && $past(ce_in) |->
    $past(lut_rd_out && lut_entry_in[0]))
    else $error("window 2 claim through a disabled page");
  a_claim1_enabled: assert property (fwd_claim1_out |->
    $past(w1_setup_in[31], 2))
    else $error("window 1 claim while disabled");
  a_claim1_space: assert property (fwd_claim1_out |->
    $past(req_io_in, 2) == $past(w1_setup_in[0], 2))
    else $error("window 1 claim of the wrong space");
  a_claim_single: assert property (fwd_claim1_out |->
    fwd_valid_out && !fwd_claim2_out)
    else $error("both windows claimed one request");
  a_pass_through: assert property (fwd_valid_out && !fwd_claim1_out &&
    !fwd_claim2_out |-> fwd_addr_out == $past(req_addr_in, 2))
    else $error("unclaimed address altered");
endmodule // uwb_top_chk
bind uwb_top uwb_top_chk u_chk (
  .sys_clk_in(sys_clk_in), .srst_in(srst_in), .ce_in(ce_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .w1_setup_in(w1_setup_in), .req_valid_in(req_valid_in),
  .req_addr_in(req_addr_in), .req_io_in(req_io_in),
  .lut_rd_out(lut_rd_out), .lut_entry_in(lut_entry_in),
  .fwd_valid_out(fwd_valid_out), .fwd_claim1_out(fwd_claim1_out),
  .fwd_claim2_out(fwd_claim2_out), .fwd_addr_out(fwd_addr_out));

// *** verif/uwb_lut_model.sv ***
// page translation table seen by window 2
`timescale 1ns/1ps
module uwb_lut_model (
  input  wire logic [5:0]  index_in,
  output logic      [31:0] entry_out
);
  // even pages enabled, odd disabled, so both outcomes are reachable
  assign entry_out = {18'h30000, index_in, 7'h00, ~index_in[0]};
endmodule // uwb_lut_model

// *** verif/test_upstream_window_base_regs.sv ***
// register and claim tests for the upstream window base block
`timescale 1ns/1ps
module test_upstream_window_base_regs;
  logic        clk = 1'b0, srst = 1'b1, ce = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0, setup = 32'h0, trans = 32'h0, raddr = 32'h0;
  logic [4:0]  code = 5'h00;
  logic        pref = 1'b0, rv = 1'b0, rio = 1'b0;
  logic [31:0] rdata, entry, faddr;
  logic [5:0]  idx;
  logic        lrd, fv, c1, c2;
  int          errors = 0, checks_done = 0;
  always #5 clk = ~clk;
  uwb_top dut (.sys_clk_in(clk), .srst_in(srst), .ce_in(ce),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s),
    .reg_rd_in(rd_s), .reg_rdata_out(rdata), .w1_setup_in(setup),
    .w1_trans_in(trans), .fwd_page_code_in(code), .w2_prefetch_in(pref),
    .req_valid_in(rv), .req_addr_in(raddr), .req_io_in(rio),
    .lut_rd_out(lrd), .lut_index_out(idx), .lut_entry_in(entry),
    .fwd_valid_out(fv), .fwd_claim1_out(c1), .fwd_claim2_out(c2),
    .fwd_addr_out(faddr));
  uwb_lut_model u_lut (.index_in(idx), .entry_out(entry));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a; rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 cmp("read data", e, rdata);
  endtask
  // answer stands one cycle, one edge after the taking edge
  task automatic req(input logic [31:0] a, input logic io,
                     input logic [31:0] ea, input logic [1:0] ec);
    @(posedge clk);
    raddr <= a; rio <= io; rv <= 1'b1;
    @(posedge clk);
    rv <= 1'b0;
    @(posedge clk);
    #1 cmp("forward valid", 32'h1, {31'h0, fv});
    cmp("claim pair", {30'h0, ec}, {30'h0, c2, c1});
    cmp("forward address", ea, faddr);
  endtask
  initial begin
    #100000;
    errors++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(12'h058, 32'h00000000);
    rd(12'h05C, 32'h00000000);
    $display("reset values done");
    setup <= 32'hFFFF0008;
    wr(12'h058, 32'hFFFFFFFF);
    rd(12'h058, 32'hFFFF0008);
    wr(12'h058, 32'h12340000);
    rd(12'h058, 32'h12340008);
    setup <= 32'hFFFFFF01;
    rd(12'h058, 32'h12340001);
    wr(12'h058, 32'hFFFFFFFF);
    rd(12'h058, 32'hFFFFFF01);
    setup <= 32'hFFFF0008;
    wr(12'h058, 32'h12340000);
    $display("window 1 fields done");
    pref <= 1'b1;
    wr(12'h05C, 32'hFFFFFFFF);
    rd(12'h05C, 32'hFFFFC008);
    code <= 5'h03;
    rd(12'h05C, 32'hFFFE0008);
    code <= 5'h00;
    wr(12'h05C, 32'h40000000);
    rd(12'h05C, 32'h40000008);
    rd(12'h204, 32'hFFFFC000);
    wr(12'h300, 32'hFFFFFFFF);
    rd(12'h300, 32'h00000000);
    $display("window 2 fields done");
    trans <= 32'hABCD0000;
    req(32'h12345678, 1'b0, 32'hABCD5678, 2'b01);
    req(32'h12345678, 1'b1, 32'h12345678, 2'b00);
    req(32'h40000234, 1'b0, 32'hC0000234, 2'b10);
    req(32'h40000334, 1'b0, 32'h40000334, 2'b00);
    rd(12'h208, 32'hC0000234);
    setup <= 32'h7FFF0008;
    req(32'h12345678, 1'b0, 32'h12345678, 2'b00);
    rd(12'h200, 32'h00000000);
    rd(12'h20C, 32'h00010001);
    wr(12'h20C, 32'h00000000);
    rd(12'h20C, 32'h00000000);
    $display("claim tests done");
    // mid-run reset clears both bases, bit 3 still follows its source
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rd(12'h058, 32'h00000008);
    rd(12'h05C, 32'h00000008);
    // a write taken while the enable is low must not land
    ce <= 1'b0;
    wr(12'h058, 32'hFFFFFFFF);
    ce <= 1'b1;
    rd(12'h058, 32'h00000008);
    $display("reset and enable tests done");
    conclude();
  end
endmodule // test_upstream_window_base_regs
